// file: hw/torque_off_pkg.sv
// Package: constants and carrier types for the torque-off monitor
package torque_off_pkg;

	// Clock rate and skew limit
	localparam int unsigned clock_hz       = 200_000_000;
	localparam int unsigned skew_limit_ms  = 1000;
	// Longest skew rounds down to whole cycles
	localparam longint unsigned skew_cycles =
		(longint'(clock_hz) * longint'(skew_limit_ms)) / 64'd1000;

	// Reset values
	localparam logic stage_enable_rst = 1'b0;

	// Monitor states, Gray-coded in the order listed
	typedef enum logic [1:0] {
		st_run     = 2'b00,
		st_skew    = 2'b01,
		st_stopped = 2'b11,
		st_discrep = 2'b10
	} monitor_e;

	// Error indications
	typedef struct packed {
		logic torque_off_error;
		logic discrepancy_error;
	} error_s;

endpackage

// file: hw/torque_off_monitor.sv
// Dual-channel safe torque off monitor for the motor power stage
//
// Operation
// [R1] Two separate redundant shut-off input channels
// [R2] Party switches both channels within one second
// [R3] Synchronous shut-off disables stage, latches error
// [R4] Re-enable only after fault-clear command
// [R5] Single or skewed shut-off latches discrepancy
// [R6] Discrepancy clears only by power cycle
// [R7] No standstill supervision, supply stays on
// [R8] Party keeps actuator power until stopped
// [R9] Quick stop first, then delayed de-assert
// [R10] Inputs synchronised, skew timed by counter
`timescale 1ns/1ps
`default_nettype none

module torque_off_monitor #(
	parameter longint unsigned skew_cycles = torque_off_pkg::skew_cycles
) (
	// Clock and power-on reset
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	// Shut-off pins, high means run permitted
	input  wire logic                  torque_off_channel_a,
	input  wire logic                  torque_off_channel_b,
	// Controller commands
	input  wire logic                  fault_clear,
	input  wire logic                  enable_request,
	// Power stage and status
	output logic                       stage_enable,
	output torque_off_pkg::error_s     error_flags
);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers, one pair per channel, never merged

	localparam int chan_n = 2;

	logic [chan_n-1:0] chan_pin;
	logic [chan_n-1:0] chan_low;
	logic [chan_n-1:0] chan_fall;

	// Bit 0 carries channel A, bit 1 channel B
	assign chan_pin[0] = torque_off_channel_a; // [R1]
	assign chan_pin[1] = torque_off_channel_b; // [R1]

	for (genvar ch = 0; ch < chan_n; ch++) begin : g_chan
		logic meta_q;
		logic sync_q;
		logic prev_q;

		// Own flops per channel, so one stuck input cannot hide
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				// Idle level is high, so reset makes no false edge
				meta_q <= 1'b1;
				sync_q <= 1'b1;
				prev_q <= 1'b1;
			end else begin
				meta_q <= chan_pin[ch]; // [R10]
				sync_q <= meta_q;
				prev_q <= sync_q;
			end
		end

		// Logic reads the second flop, and the third as well for the falling edge
		assign chan_low[ch]  = ~sync_q;
		assign chan_fall[ch] = prev_q & ~sync_q;
	end

	////////////////////////////////////////////////////////////////////
	// Monitor state and skew counter

	localparam int cnt_w = $clog2(skew_cycles + 1);

	// Last count still inside the permitted skew
	localparam logic [cnt_w-1:0] skew_last = cnt_w'(skew_cycles - 1);

	torque_off_pkg::monitor_e state_q;
	torque_off_pkg::monitor_e state_d;
	logic [cnt_w-1:0]         skew_cnt_q;
	logic [cnt_w-1:0]         skew_cnt_d;
	logic                     first_chan_q;
	logic                     first_chan_d;
	logic                     set_stop;
	logic                     set_discrep;

	always_comb begin
		state_d      = state_q;
		skew_cnt_d   = skew_cnt_q;
		first_chan_d = first_chan_q;
		set_stop     = 1'b0;
		set_discrep  = 1'b0;
		case (state_q)
			torque_off_pkg::st_run: begin
				skew_cnt_d = '0;
				if (chan_low == 2'h3) begin
					// Both fell in the same cycle
					state_d  = torque_off_pkg::st_stopped;
					set_stop = 1'b1; // [R3]
				end else if (chan_low != 2'h0) begin
					// One channel first: time how long the other lags
					state_d      = torque_off_pkg::st_skew;
					first_chan_d = chan_low[1];
				end
			end
			torque_off_pkg::st_skew: begin
				skew_cnt_d = skew_cnt_q + cnt_w'(1); // [R10]
				if (chan_low == 2'h3) begin
					state_d    = torque_off_pkg::st_stopped;
					skew_cnt_d = '0;
					set_stop   = 1'b1; // [R3]
				end else if (!chan_low[first_chan_q] ||
				             skew_cnt_q >= skew_last) begin
					// Channel recovered alone or second one too late
					state_d     = torque_off_pkg::st_discrep;
					set_discrep = 1'b1; // [R5]
				end
			end
			torque_off_pkg::st_stopped: begin
				if (chan_low == 2'h0) begin
					state_d = torque_off_pkg::st_run;
				end else if (chan_low != 2'h3) begin
					// Channels coming back apart are timed as well
					skew_cnt_d = skew_cnt_q + cnt_w'(1); // [R10]
					if (skew_cnt_q >= skew_last) begin
						state_d     = torque_off_pkg::st_discrep;
						set_discrep = 1'b1; // [R5]
					end
				end else begin
					skew_cnt_d = '0;
				end
			end
			torque_off_pkg::st_discrep: begin
				// Sticky: no way out but power-on reset
				state_d = torque_off_pkg::st_discrep; // [R6]
			end
			default: begin
				state_d = torque_off_pkg::st_discrep;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q      <= torque_off_pkg::st_run;
			skew_cnt_q   <= '0;
			first_chan_q <= 1'b0;
		end else begin
			state_q      <= state_d;
			skew_cnt_q   <= skew_cnt_d;
			first_chan_q <= first_chan_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Latched errors

	torque_off_pkg::error_s err_q;
	torque_off_pkg::error_s err_d;

	always_comb begin
		err_d = err_q;
		// Clear reaches only the resettable error, with inputs back up
		if (fault_clear && state_q == torque_off_pkg::st_run &&
		    chan_low == 2'h0 && chan_fall == 2'h0) begin
			err_d.torque_off_error = 1'b0; // [R4]
		end
		// A shut-off in the same cycle as a clear wins
		if (set_stop) begin
			err_d.torque_off_error = 1'b1; // [R3]
		end
		// Nothing here ever clears this bit
		if (set_discrep) begin
			err_d.discrepancy_error = 1'b1; // [R6]
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			err_q <= '0;
		end else begin
			err_q <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Power stage enable

	logic enable_q;
	logic enable_d;

	always_comb begin
		enable_d = enable_q;
		if (chan_low != 2'h0 || state_q != torque_off_pkg::st_run) begin
			// First channel seen low drops the stage at once
			enable_d = 1'b0; // [R5]
		end else if (err_q != '0) begin
			// Either error blocks a restart until it is gone
			enable_d = 1'b0; // [R4]
		end else if (enable_request) begin
			enable_d = 1'b1; // [R4]
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			enable_q <= torque_off_pkg::stage_enable_rst;
		end else begin
			enable_q <= enable_d;
		end
	end

	// Stage only: supply and standstill are not watched here
	assign stage_enable = enable_q; // [R7]
	assign error_flags  = err_q;

endmodule

`default_nettype wire

// file: testbench/torque_off_checker.sv
// Port checker for the torque-off monitor
`timescale 1ns/1ps
`default_nettype none
module torque_off_checker #(
	parameter longint unsigned skew_cycles = 20
) (
	// Clock, pins, commands, outputs
	input wire logic                   clock,
	input wire logic                   rst_b,
	input wire logic                   torque_off_channel_a,
	input wire logic                   torque_off_channel_b,
	input wire logic                   fault_clear,
	input wire logic                   enable_request,
	input wire logic                   stage_enable,
	input wire torque_off_pkg::error_s error_flags
);
	wire logic a = torque_off_channel_a;
	wire logic b = torque_off_channel_b;
	wire logic e = error_flags.torque_off_error;
	wire logic d = error_flags.discrepancy_error;
	int        cnt_q;
	int        cnt_d;
	// Cycles the pins disagree
	always_comb cnt_d = (a != b) ? cnt_q + 1 : 0;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) cnt_q <= 0;
		else cnt_q <= cnt_d;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	chk_both_off: assert property (
		$fell(a) && $fell(b) && !d |-> ##[1:4] e)
		else $error("shut-off error missing");
	chk_one_off: assert property (
		$fell(a) |-> ##[1:4] !stage_enable)
		else $error("stage not disabled");
	chk_b_off: assert property (
		$fell(b) |-> ##[1:4] !stage_enable)
		else $error("stage not disabled on channel b");
	chk_err_stage: assert property (
		e || d |-> !stage_enable)
		else $error("stage on with error");
	chk_disc_sticky: assert property (
		d |=> d)
		else $error("discrepancy cleared");
	chk_err_clear: assert property (
		$fell(e) |-> $past(fault_clear) && $past(a, 3) && $past(b, 3))
		else $error("error cleared without command");
	chk_enable_cause: assert property (
		$rose(stage_enable) |->
		$past(enable_request) && !$past(e) && !$past(d))
		else $error("stage on without request");
	chk_skew_timeout: assert property (
		cnt_q > skew_cycles + 5 |-> d)
		else $error("skew not timed out");
endmodule
bind torque_off_monitor torque_off_checker #(.skew_cycles(skew_cycles)) i_chk (
	.clock(clock), .rst_b(rst_b), .torque_off_channel_a(torque_off_channel_a),
	.torque_off_channel_b(torque_off_channel_b), .fault_clear(fault_clear),
	.enable_request(enable_request), .stage_enable(stage_enable),
	.error_flags(error_flags));
`default_nettype wire

// file: testbench/estop_model.sv
// Emergency-stop partner driving both shut-off channels
`timescale 1ns/1ps
`default_nettype none
module estop_model (
	input  wire logic clock,
	output var logic  chan_a,
	output var logic  chan_b
);
	initial begin
		chan_a = 1'b1;
		chan_b = 1'b1;
	end
	// Lead channel drops, the other follows sk cycles later unless one is set, then it stays up
	task automatic drop(input int sk, input bit one, input bit lead_b);
		@(posedge clock);
		if (lead_b) chan_b <= 1'b0;
		else chan_a <= 1'b0;
		repeat (sk) @(posedge clock);
		if (!one && lead_b) chan_a <= 1'b0;
		else if (!one) chan_b <= 1'b0;
	endtask
	task automatic raise();
		@(posedge clock) chan_a <= 1'b1;
		chan_b <= 1'b1;
	endtask
	// Channel A alone back up, B stays off
	task automatic raise_one();
		@(posedge clock) chan_a <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: testbench/dual_channel_torque_off_monitor_bench.sv
// Self-checking bench for the torque-off monitor
`timescale 1ns/1ps
`default_nettype none
module dual_channel_torque_off_monitor_bench;
	localparam int skew = 20;
	logic clock, rst_b, fault_clear, enable_request, stage_enable, a, b;
	torque_off_pkg::error_s error_flags;
	int mismatches, checks, cycles, exp_e, exp_d, sk;
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	estop_model i_estop_model (.clock(clock), .chan_a(a), .chan_b(b));
	torque_off_monitor #(.skew_cycles(skew)) i_torque_off_monitor (
		.clock(clock), .rst_b(rst_b), .torque_off_channel_a(a),
		.torque_off_channel_b(b), .fault_clear(fault_clear),
		.enable_request(enable_request), .stage_enable(stage_enable),
		.error_flags(error_flags));
	task automatic cmp(input string n, input int e, input logic g);
		checks++;
		if (g !== 1'(e)) begin
			mismatches++;
			$display("ERROR %s expected %0d seen %b", n, e, g);
		end
	endtask
	task automatic outs(input int st);
		cmp("stage_enable", st, stage_enable);
		cmp("torque_off_error", exp_e, error_flags.torque_off_error);
		cmp("discrepancy_error", exp_d, error_flags.discrepancy_error);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic pulse_clear();
		@(posedge clock) fault_clear <= 1'b1;
		@(posedge clock) fault_clear <= 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard, well above the run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		rst_b = 1'b0;
		fault_clear = 1'b0;
		enable_request = 1'b0;
		sk = $urandom(51);
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		tick(2);
		outs(0);
		@(posedge clock) enable_request <= 1'b1;
		tick(3);
		outs(1);
		for (int k = 0; k < 5; k++) begin
			sk = (k == 0) ? 0 : (k == 1) ? skew - 6 : $urandom % (skew - 6);
			i_estop_model.drop(sk, 1'b0, k[0]);
			exp_e = 1;
			tick(6);
			outs(0);
			i_estop_model.raise();
			tick(6);
			outs(0);
			pulse_clear();
			exp_e = 0;
			tick(3);
			outs(1);
		end
		i_estop_model.drop(0, 1'b1, 1'b0);
		exp_d = 1;
		tick(skew + 10);
		outs(0);
		i_estop_model.raise();
		tick(6);
		pulse_clear();
		tick(3);
		outs(0);
		@(posedge clock) rst_b <= 1'b0;
		@(posedge clock) rst_b <= 1'b1;
		exp_d = 0;
		tick(4);
		outs(1);
		i_estop_model.drop(0, 1'b1, 1'b0);
		tick(4);
		i_estop_model.raise();
		exp_d = 1;
		tick(6);
		outs(0);
		@(posedge clock) rst_b <= 1'b0;
		@(posedge clock) rst_b <= 1'b1;
		exp_d = 0;
		tick(4);
		outs(1);
		i_estop_model.drop(0, 1'b0, 1'b0);
		exp_e = 1;
		tick(6);
		outs(0);
		i_estop_model.raise_one();
		exp_d = 1;
		tick(skew + 10);
		outs(0);
		test_done();
	end
endmodule
`default_nettype wire
